// ---- gafm_board.sv ----
// Board side of the six pins: wires, pull-ups and board drivers.
// Assumes open-drain style sharing, so a low from either side wins.
`timescale 1ns/1ps
module gafm_board (
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] board_oe,
   input wire logic [5:0] board_val,
   output logic [5:0] pin_in
);
   // Undriven lines float high, the inactive level of the low-active pins.
   assign pin_in = (pin_out | ~pin_oe) & (board_val | ~board_oe);
endmodule // gafm_board

// ---- gafm_monitor.sv ----
// Port checker for the GPIO alternate function multiplexer.
// Assumes binding onto gafm_mux and a single core clock domain.
`timescale 1ns/1ps
module gafm_monitor
   import gafm_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic sw_cfg_write,
   input wire logic smbus_cfg_write,
   input wire logic [11:0] sw_fn_sel,
   input wire logic [11:0] smbus_fn_sel,
   input wire logic [5:0] gpio_dir,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic [3:0] partition_reset_req_n,
   input wire logic [3:0] partition_reset,
   input wire logic failover_event,
   input wire logic hotplug_event_n,
   input wire logic port0_link_up,
   input wire logic port0_link_active,
   input wire logic port16_link_up,
   input wire logic port16_link_active,
   input wire logic [11:0] fn_sel,
   input wire logic [1:0] cfg_source
);
////////////////////////////////////////////////////////////////////////////
   // All checks run on the core clock and pause in reset.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // A partition request is seen as a reset one cycle later.
   sequence s_preq;
      !partition_reset_req_n[1] ##1 partition_reset[1];
   endsequence
   // A running partition reset then holds its own pin low.
   sequence s_pin_hold;
      partition_reset[2] && fn_sel[5:4] == 2'h1 ##1 pin_oe[2] && !pin_out[2];
   endsequence
   chk_sw_select: assert property (sw_cfg_write |=>
      fn_sel == $past(sw_fn_sel) && cfg_source == 2'h0)
      else $error("software selection not taken");
   chk_smbus_select: assert property (smbus_cfg_write && !sw_cfg_write |=>
      fn_sel == $past(smbus_fn_sel) && cfg_source == 2'h1)
      else $error("serial selection not taken");
   chk_part_req: assert property (!partition_reset_req_n[1] |-> s_preq)
      else $error("partition reset not started");
   chk_part_pin: assert property (partition_reset[2] && fn_sel[5:4] == 2'h1
      |-> s_pin_hold)
      else $error("partition pin not held low");
   chk_fail_pulse: assert property (failover_event |=> !failover_event)
      else $error("failover event too long");
   chk_p0_up: assert property (fn_sel[9:8] == 2'h2 |=>
      pin_oe[4] && pin_out[4] == !$past(port0_link_up))
      else $error("port 0 link up pin wrong");
   chk_hp_event: assert property (fn_sel[11:10] == 2'h1 |=>
      pin_oe[5] && pin_out[5] == $past(hotplug_event_n))
      else $error("hot-plug event pin wrong");
   chk_p0_act: assert property (fn_sel[11:10] == 2'h2 |=>
      pin_oe[5] && pin_out[5] == !$past(port0_link_active))
      else $error("port 0 link active pin wrong");
   chk_p16_up: assert property (fn_sel[1:0] == 2'h2 |=>
      pin_oe[0] && pin_out[0] == !$past(port16_link_up))
      else $error("port 16 link up pin wrong");
   chk_p16_act: assert property (fn_sel[3:2] == 2'h2 |=>
      pin_oe[1] && pin_out[1] == !$past(port16_link_active))
      else $error("port 16 link active pin wrong");
   chk_gpio_dir: assert property (fn_sel[7:6] == 2'h0 |=>
      pin_oe[3] == $past(gpio_dir[3]))
      else $error("gpio direction not followed");
endmodule // gafm_monitor
////////////////////////////////////////////////////////////////////////////
bind gafm_mux gafm_monitor u_mon (.core_clk(core_clk), .reset_n(reset_n),
   .sw_cfg_write(sw_cfg_write), .smbus_cfg_write(smbus_cfg_write),
   .sw_fn_sel(sw_fn_sel), .smbus_fn_sel(smbus_fn_sel),
   .gpio_dir(gpio_dir), .pin_out(pin_out), .pin_oe(pin_oe),
   .partition_reset_req_n(partition_reset_req_n),
   .partition_reset(partition_reset), .failover_event(failover_event),
   .hotplug_event_n(hotplug_event_n), .port0_link_up(port0_link_up),
   .port0_link_active(port0_link_active), .port16_link_up(port16_link_up),
   .port16_link_active(port16_link_active), .fn_sel(fn_sel),
   .cfg_source(cfg_source));

// ---- gafm_mux.sv ----
// GPIO alternate function multiplexer for pins zero to five.
// Assumes the configuration agents present one-cycle write strobes and
// that link status inputs are on the core clock.
// Function
// - Each pin selects plain GPIO or one of its alternate functions.
// - Alt one on pins zero to three is a partition reset line.
// - Alt one on pin four: any edge is a failover event if enabled.
// - Alt two on pin four drives port 0 link up status.
// - Alt one on pin five drives the hot-plug event output.
// - Alt two on pin five drives port 0 link active status.
// - Alt two on pin zero drives port 16 link up status.
// - Alt two on pin one drives port 16 link active status.
// - Names ending in _n are active low; all others active high.
// - Selection is written by software, the SMBus slave, or EEPROM.
`timescale 1ns/1ps
`include "gafm_params.svh"
module gafm_mux
   import gafm_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic sw_cfg_write,
   input wire logic smbus_cfg_write,
   input wire logic eeprom_cfg_write,
   input wire logic [11:0] sw_fn_sel,
   input wire logic [11:0] smbus_fn_sel,
   input wire logic [11:0] eeprom_fn_sel,
   input wire logic [5:0] gpio_dir,
   input wire logic [5:0] gpio_out,
   output logic [5:0] gpio_in,
   input wire logic [5:0] pin_in,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe,
   input wire logic [3:0] partition_reset_req_n,
   output logic [3:0] partition_reset,
   input wire logic failover_enable,
   output logic failover_event,
   input wire logic hotplug_event_n,
   input wire logic port0_link_up,
   input wire logic port0_link_active,
   input wire logic port16_link_up,
   input wire logic port16_link_active,
   output logic [11:0] fn_sel,
   output logic [1:0] cfg_source
);
   logic [5:0] sync_level;
   logic [11:0] next_fn_sel;
   logic [1:0] next_cfg_source;
   logic failover_prev;
   logic next_failover_prev;
   logic next_failover_event;
   logic [3:0] next_partition_reset;
   logic [3:0] preset_req;
   logic [5:0] next_pin_out;
   logic [5:0] next_pin_oe;
   logic [5:0] gpio_in_q;
   logic [7:0] preset_cnt [3:0];
   logic [7:0] next_preset_cnt [3:0];
   logic failover_in0;
   logic partition0_reset_n;
   logic partition1_reset_n;
   logic partition2_reset_n;
   logic partition3_reset_n;
   logic port0_link_up_n;
   logic port0_link_active_n;
   logic port16_link_up_n;
   logic port16_link_active_n;
   logic hotplug_event_out_n;
   logic [3:0] part_pin_n;
   logic [3:0] preset_pin_prev;
   logic [3:0] next_preset_pin_prev;

   // Field decode shared by every pin.
   function automatic gafm_fn_type pin_fn(input logic [11:0] sel,
                                          input int idx);
      pin_fn = gafm_fn_type'(sel[2*idx +: 2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Synchronise every pin; failover and reset inputs read only the result.
   for (genvar i = 0; i < `GAFM_PIN_COUNT; i++) begin : g_sync
      gafm_sync u_sync (
         .core_clk(core_clk),
         .reset_n(reset_n),
         .pin_in(pin_in[i]),
         .level(sync_level[i])
      );
   end

   // Active-low pin levels for the alternate functions.
   assign partition0_reset_n = sync_level[0];
   assign partition1_reset_n = sync_level[1];
   assign partition2_reset_n = sync_level[2];
   assign partition3_reset_n = sync_level[3];
   assign part_pin_n = {partition3_reset_n, partition2_reset_n,
                        partition1_reset_n, partition0_reset_n};
   assign failover_in0 = sync_level[`GAFM_FAILOVER_PIN];
   assign port0_link_up_n = ~port0_link_up;
   assign port0_link_active_n = ~port0_link_active;
   assign port16_link_up_n = ~port16_link_up;
   assign port16_link_active_n = ~port16_link_active;
   assign hotplug_event_out_n = hotplug_event_n;

   ////////////////////////////////////////////////////////////////////////
   // Selection register; software wins over SMBus, SMBus over EEPROM.
   always_comb begin
      next_fn_sel = fn_sel;
      next_cfg_source = cfg_source;
      if (sw_cfg_write) begin
         next_fn_sel = sw_fn_sel;
         next_cfg_source = gafm_src_sw;
      end else if (smbus_cfg_write) begin
         next_fn_sel = smbus_fn_sel;
         next_cfg_source = gafm_src_smbus;
      end else if (eeprom_cfg_write) begin
         next_fn_sel = eeprom_fn_sel;
         next_cfg_source = gafm_src_eeprom;
      end
   end

   // Register the selection.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fn_sel <= {`GAFM_PIN_COUNT{`GAFM_SEL_RESET}};
         cfg_source <= gafm_src_sw;
      end else begin
         fn_sel <= next_fn_sel;
         cfg_source <= next_cfg_source;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers; partition reset pins drive low while that reset runs.
   always_comb begin
      next_pin_out = gpio_out;
      next_pin_oe = gpio_dir;
      for (int i = 0; i < `GAFM_PIN_COUNT; i++) begin
         unique case (pin_fn(fn_sel, i))
            gafm_fn_gpio: begin
               next_pin_out[i] = gpio_out[i];
               next_pin_oe[i] = gpio_dir[i];
            end
            gafm_fn_alt1: begin
               next_pin_out[i] = 1'h0;
               next_pin_oe[i] = 1'h0;
               if (i < `GAFM_PART_COUNT) begin
                  next_pin_oe[i] = partition_reset[i];
               end else if (i == `GAFM_HOTPLUG_PIN) begin
                  next_pin_out[i] = hotplug_event_out_n;
                  next_pin_oe[i] = 1'h1;
               end
            end
            gafm_fn_alt2: begin
               next_pin_out[i] = 1'h1;
               next_pin_oe[i] = 1'h0;
               if (i == 0) begin
                  next_pin_out[i] = port16_link_up_n;
                  next_pin_oe[i] = 1'h1;
               end else if (i == 1) begin
                  next_pin_out[i] = port16_link_active_n;
                  next_pin_oe[i] = 1'h1;
               end else if (i == `GAFM_FAILOVER_PIN) begin
                  next_pin_out[i] = port0_link_up_n;
                  next_pin_oe[i] = 1'h1;
               end else if (i == `GAFM_HOTPLUG_PIN) begin
                  next_pin_out[i] = port0_link_active_n;
                  next_pin_oe[i] = 1'h1;
               end
            end
            default: begin
               next_pin_out[i] = 1'h0;
               next_pin_oe[i] = 1'h0;
            end
         endcase
      end
   end

   // Register pin drive and the sampled levels returned on read.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out <= `GAFM_OUT_RESET;
         pin_oe <= `GAFM_DIR_RESET;
         gpio_in_q <= 6'h3F;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         gpio_in_q <= sync_level;
      end
   end
   assign gpio_in = gpio_in_q;

   ////////////////////////////////////////////////////////////////////////
   // Partition reset: a falling pin or an internal request starts a timed
   // reset.
   always_comb begin
      for (int p = 0; p < `GAFM_PART_COUNT; p++) begin
         preset_req[p] = ~partition_reset_req_n[p];
         next_preset_pin_prev[p] = part_pin_n[p];
         // Only a fall that this block is not driving itself counts, so its
         // own low drive cannot keep the reset running for ever.
         if (pin_fn(fn_sel, p) == gafm_fn_alt1 && !pin_oe[p] &&
             preset_pin_prev[p] && !part_pin_n[p]) begin
            preset_req[p] = 1'h1;
         end
         next_preset_cnt[p] = preset_cnt[p];
         if (preset_req[p]) begin
            next_preset_cnt[p] = 8'(`GAFM_PRESET_CYCLES);
         end else if (preset_cnt[p] != 8'h00) begin
            next_preset_cnt[p] = preset_cnt[p] - 8'h01;
         end
         next_partition_reset[p] = next_preset_cnt[p] != 8'h00;
      end
   end

   // Register the reset timers.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int p = 0; p < `GAFM_PART_COUNT; p++) begin
            preset_cnt[p] <= 8'h00;
         end
         partition_reset <= 4'h0;
         preset_pin_prev <= {`GAFM_PART_COUNT{`GAFM_SYNC_RESET}};
      end else begin
         for (int p = 0; p < `GAFM_PART_COUNT; p++) begin
            preset_cnt[p] <= next_preset_cnt[p];
         end
         partition_reset <= next_partition_reset;
         preset_pin_prev <= next_preset_pin_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Failover: each filtered edge on pin four is a one-cycle event.
   always_comb begin
      next_failover_prev = failover_in0;
      next_failover_event = 1'h0;
      if (pin_fn(fn_sel, `GAFM_FAILOVER_PIN) == gafm_fn_alt1 &&
          failover_enable && failover_in0 != failover_prev) begin
         next_failover_event = 1'h1;
      end
   end

   // Register the failover edge detector.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         failover_prev <= `GAFM_SYNC_RESET;
         failover_event <= 1'h0;
      end else begin
         failover_prev <= next_failover_prev;
         failover_event <= next_failover_event;
      end
   end
endmodule // gafm_mux

// ---- gafm_params.svh ----
// Constants for the GPIO alternate function multiplexer.
// Assumes inclusion by gafm_pkg.sv, the design modules and the bench.
`ifndef GAFM_PARAMS_SVH
`define GAFM_PARAMS_SVH
`define GAFM_PIN_COUNT 6
`define GAFM_PART_COUNT 4
`define GAFM_FAILOVER_PIN 4
`define GAFM_HOTPLUG_PIN 5
`define GAFM_SEL_RESET 2'h0
`define GAFM_DIR_RESET 6'h00
`define GAFM_OUT_RESET 6'h3F
`define GAFM_SYNC_RESET 1'h1
`define GAFM_PRESET_TIME_NS 1000
`define GAFM_CLK_PERIOD_NS 25
`define GAFM_PRESET_CYCLES ((`GAFM_PRESET_TIME_NS + `GAFM_CLK_PERIOD_NS - 1) / `GAFM_CLK_PERIOD_NS)
`endif

// ---- gafm_pkg.sv ----
// Types for the GPIO alternate function multiplexer.
// Assumes gafm_params.svh is on the include path.
`include "gafm_params.svh"
package gafm_pkg;
   // Per-pin function selection.
   typedef enum logic [1:0] {
      gafm_fn_gpio = 2'h0,
      gafm_fn_alt1 = 2'h1,
      gafm_fn_alt2 = 2'h2,
      gafm_fn_rsvd = 2'h3
   } gafm_fn_type;
   // Source that last wrote the selection.
   typedef enum logic [1:0] {
      gafm_src_sw = 2'h0,
      gafm_src_smbus = 2'h1,
      gafm_src_eeprom = 2'h2
   } gafm_src_type;
endpackage

// ---- gafm_sync.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous pin level and one core clock.
`timescale 1ns/1ps
`include "gafm_params.svh"
module gafm_sync
   import gafm_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic pin_in,
   output logic level
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic next_level;
   ////////////////////////////////////////////////////////////////////////
   // Shift the pin in; the level only moves when stages two and three agree.
   always_comb begin
      next_stage = {stage[1:0], pin_in};
      next_level = (stage[2] == stage[1]) ? stage[2] : level;
   end
   // Register the stages and the filtered level.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage <= {3{`GAFM_SYNC_RESET}};
         level <= `GAFM_SYNC_RESET;
      end else begin
         stage <= next_stage;
         level <= next_level;
      end
   end
endmodule // gafm_sync

// ---- tb_top.sv ----
// Self-checking bench for the GPIO alternate function multiplexer.
// Assumes gafm_pkg, gafm_mux, gafm_board and the checker are compiled.
`timescale 1ns/1ps
`include "gafm_params.svh"
module tb_top;
   import gafm_pkg::*;
   logic core_clk, reset_n, sw_cfg_write, smbus_cfg_write, eeprom_cfg_write;
   logic [11:0] sw_fn_sel, smbus_fn_sel, eeprom_fn_sel, fn_sel;
   logic [5:0] gpio_dir, gpio_out, gpio_in, pin_in, pin_out, pin_oe;
   logic [5:0] board_oe, board_val;
   logic [3:0] partition_reset_req_n, partition_reset, lk;
   logic failover_enable, failover_event, hotplug_event_n;
   logic [1:0] cfg_source;
   int fails = 0;
   int compares = 0;
   int n;
////////////////////////////////////////////////////////////////////////////
   // Device and board wiring.
   gafm_mux u_dut (.core_clk(core_clk), .reset_n(reset_n),
      .sw_cfg_write(sw_cfg_write), .smbus_cfg_write(smbus_cfg_write),
      .eeprom_cfg_write(eeprom_cfg_write), .sw_fn_sel(sw_fn_sel),
      .smbus_fn_sel(smbus_fn_sel), .eeprom_fn_sel(eeprom_fn_sel),
      .gpio_dir(gpio_dir), .gpio_out(gpio_out), .gpio_in(gpio_in),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .partition_reset_req_n(partition_reset_req_n),
      .partition_reset(partition_reset), .failover_enable(failover_enable),
      .failover_event(failover_event), .hotplug_event_n(hotplug_event_n),
      .port0_link_up(lk[2]), .port0_link_active(lk[3]),
      .port16_link_up(lk[0]), .port16_link_active(lk[1]),
      .fn_sel(fn_sel), .cfg_source(cfg_source));
   gafm_board u_board (.pin_out(pin_out), .pin_oe(pin_oe),
      .board_oe(board_oe), .board_val(board_val), .pin_in(pin_in));
////////////////////////////////////////////////////////////////////////////
   // Shared helpers: compare, wait, select, count.
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic sel(input logic [11:0] v);
      @(posedge core_clk);
      sw_fn_sel <= v;
      sw_cfg_write <= 1'b1;
      @(posedge core_clk);
      sw_cfg_write <= 1'b0;
      cyc(3);
   endtask
   task automatic count_hi(input int k, input int b);
      n = 0;
      repeat (k) begin
         cyc(1);
         n += (b == 4) ? int'(failover_event) : int'(partition_reset[b]);
      end
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_gpio;
      @(posedge core_clk);
      gpio_dir <= 6'h3F;
      gpio_out <= 6'h2A;
      sel(12'h000);
      cyc(6);
      chk({pin_oe, pin_out}, 12'hFEA);
      chk({6'h00, gpio_in}, 12'h02A);
      gpio_dir <= 6'h00;
      board_oe <= 6'h3F;
      board_val <= 6'h15;
      cyc(8);
      chk({pin_oe, gpio_in}, 12'h015);
      board_oe <= 6'h00;
   endtask
   task automatic t_alt;
      sel(12'hA0A);
      for (int p = 0; p < 2; p++) begin
         lk <= p ? 4'hA : 4'h5;
         cyc(3);
         chk({pin_oe, pin_out & 6'h33}, {6'h33, ~lk[3:2], 2'h0, ~lk[1:0]});
      end
      sel(12'h400);
      for (int v = 0; v < 2; v++) begin
         hotplug_event_n <= v[0];
         cyc(3);
         chk({pin_oe, 5'h00, pin_out[5]}, {6'h20, 5'h00, v[0]});
      end
   endtask
   task automatic t_prio;
      @(posedge core_clk);
      {sw_fn_sel, smbus_fn_sel, eeprom_fn_sel} <= {12'h111, 12'h222, 12'h333};
      {sw_cfg_write, smbus_cfg_write, eeprom_cfg_write} <= 3'h7;
      @(posedge core_clk);
      sw_cfg_write <= 1'b0;
      cyc(0);
      chk({cfg_source, fn_sel[9:0]}, 12'h111);
      // Each lower-priority strobe stands until the edge that takes it.
      cyc(1);
      smbus_cfg_write <= 1'b0;
      chk({cfg_source, fn_sel[9:0]}, 12'h622);
      cyc(1);
      eeprom_cfg_write <= 1'b0;
      chk({cfg_source, fn_sel[9:0]}, 12'hB33);
   endtask
   task automatic t_fail;
      sel(12'h100);
      for (int e = 1; e >= 0; e--) begin
         failover_enable <= e[0];
         board_oe <= 6'h10;
         board_val <= 6'h00;
         count_hi(12, 4);
         chk(12'(n), 12'(e));
         board_val <= 6'h10;
         count_hi(12, 4);
         chk(12'(n), 12'(e));
      end
      chk({6'h00, pin_oe}, 12'h000);
      board_oe <= 6'h00;
   endtask
   task automatic t_preset;
      sel(12'h000);
      partition_reset_req_n <= 4'hD;
      cyc(1);
      partition_reset_req_n <= 4'hF;
      count_hi(60, 1);
      // The first reset cycle passes before counting starts.
      chk(12'(n + 1), 12'(`GAFM_PRESET_CYCLES));
      sel(12'h010);
      board_oe <= 6'h04;
      cyc(8);
      chk({partition_reset, pin_oe[2], pin_out[2]}, 12'h012);
      // The reset must end although the board still holds the pin low.
      count_hi(60, 2);
      chk({6'h00, partition_reset, pin_oe[3:2]}, 12'h000);
      reset_n <= 1'b0;
      board_oe <= 6'h00;
      cyc(2);
      chk({fn_sel[3:0], partition_reset, pin_oe[3:0]}, 12'h000);
   endtask
////////////////////////////////////////////////////////////////////////////
   // Clock, stimulus sequence and watchdog.
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      reset_n = 1'b0;
      {sw_cfg_write, smbus_cfg_write, eeprom_cfg_write} = 3'h0;
      {sw_fn_sel, smbus_fn_sel, eeprom_fn_sel} = 36'h0;
      {gpio_dir, gpio_out, board_oe, board_val} = 24'h0;
      partition_reset_req_n = 4'hF;
      {failover_enable, hotplug_event_n, lk} = 6'h10;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      cyc(1);
      chk({gpio_in, pin_oe}, 12'hFC0);
      chk({fn_sel[9:0], cfg_source}, 12'h000);
      t_gpio;
      t_alt;
      t_prio;
      t_fail;
      t_preset;
      end_of_test;
   end
   initial begin
      #200000;
      fails++;
      end_of_test;
   end
endmodule // tb_top
